// >>> rtl/mic_pkg.sv
// Shared constants of the microcontroller interrupt controller.
// Assumes an AXI4-Lite register bus with 32-bit data and a four-phase instruction cycle.
package mic_pkg;
	// Register byte offsets.
	localparam logic [11:0] OFS_MAIN_CTRL = 12'h000;
	localparam logic [11:0] OFS_FLAG_ONE = 12'h004;
	localparam logic [11:0] OFS_FLAG_TWO = 12'h008;
	localparam logic [11:0] OFS_FLAG_THREE = 12'h00c;
	localparam logic [11:0] OFS_EN_ONE = 12'h010;
	localparam logic [11:0] OFS_EN_TWO = 12'h014;
	localparam logic [11:0] OFS_EN_THREE = 12'h018;
	localparam logic [11:0] OFS_OPTION = 12'h01c;
	localparam logic [11:0] OFS_PIN_FLAGS = 12'h020;
	localparam logic [11:0] OFS_PIN_RISE_EN = 12'h024;
	localparam logic [11:0] OFS_PIN_FALL_EN = 12'h028;
	localparam logic [11:0] OFS_SEQ_STATUS = 12'h02c;

	// Field positions of the main control register.
	localparam int BIT_GLOBAL_EN = 7;
	localparam int BIT_PERIPH_EN = 6;
	localparam int BIT_TMR_EN = 5;
	localparam int BIT_EXT_EN = 4;
	localparam int BIT_PINCHG_EN = 3;
	localparam int BIT_TMR_FLAG = 2;
	localparam int BIT_EXT_FLAG = 1;
	localparam int BIT_PINCHG_SUM = 0;
	// Field position of the edge select in the option register.
	localparam int BIT_EDGE_SEL = 6;

	localparam int PIN_COUNT = 6;

	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [PIN_COUNT-1:0] RST_PINS = 6'h00;

	// Interrupt vector.
	localparam logic [14:0] IRQ_VECTOR = 15'h0004;

	// Quadrature phase codes.
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q4 = 2'h3;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MIC_IDLE = 2'b00,
		MIC_FLUSH = 2'b01,
		MIC_SAVE = 2'b10,
		MIC_VECTOR = 2'b11
	} mic_state_t;
endpackage

// >>> rtl/mic_irq_ctrl.sv
// Interrupt controller of a small microcontroller with AXI4-Lite registers.
// Assumes a core that follows the entry strobes and pulses return_from_irq_instr.
// What this block does
// - Any reset leaves all enables clear, so nothing can redirect execution.
// - Redirect only with global and own enable, peripherals also need group enable.
// - Every source flag sets on its event whatever the enables are.
// - Flags live in the main control register, three peripheral flag registers and the pin flag register.
// - On entry flush prefetch, clear global enable, push PC, save shadow, load vector.
// - With global enable clear events only flag; pending ones taken once re-enabled.
// - Return pops address, restores shadow context and sets global enable again.
// - Synchronous sources reach the vector three or four instruction cycles later.
// - Asynchronous sources reach the vector three to five instruction cycles later.
// - Entry latency does not depend on one- or two-cycle instructions.
// - The external pin flag is sampled at the first phase of each cycle.
// - The external pin flag may become set between the fourth and first phase.
// - Edge select set means rising edge sets the pin flag, clear means falling.
// - Shadow save holds W, status less time-out and power-down, bank, pointers, latch.
// - Pin-change summary flag is read-only and clears once all pin flags clear.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// AXI4-Lite write address and data.
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response.
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read.
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Event sources.
	input wire logic timer_ovf_event,
	input wire logic [7:0] periph_event_one,
	input wire logic [7:0] periph_event_two,
	input wire logic [7:0] periph_event_three,
	input wire logic ext_irq_pin,
	input wire logic [mic_pkg::PIN_COUNT-1:0] pin_change_pins,
	// Core side.
	output logic [1:0] q_phase,
	input wire logic [14:0] core_pc,
	input wire logic [7:0] core_w,
	input wire logic [2:0] core_status,
	input wire logic [4:0] core_bsr,
	input wire logic [15:0] core_fsr0,
	input wire logic [15:0] core_fsr1,
	input wire logic [6:0] core_pclath,
	input wire logic return_from_irq_instr,
	output logic irq_flush,
	output logic stack_push,
	output logic [14:0] push_addr,
	output logic pc_load,
	output logic [14:0] pc_load_addr,
	output logic ctx_restore,
	output logic [7:0] shadow_w,
	output logic [2:0] shadow_status,
	output logic [4:0] shadow_bsr,
	output logic [15:0] shadow_fsr0,
	output logic [15:0] shadow_fsr1,
	output logic [6:0] shadow_pclath
);
	import mic_pkg::*;

	mic_state_t state;
	logic global_irq_enable, peripheral_group_enable, tmr_en, ext_en, pinchg_en;
	logic tmr_flag, ext_pin_irq_flag, ext_pin_edge_select;
	logic [7:0] periph_flag_reg_one, periph_flag_reg_two, periph_flag_reg_three;
	logic [7:0] periph_enable_reg_one, periph_enable_reg_two, periph_enable_reg_three;
	logic [PIN_COUNT-1:0] pin_flags, pin_rise_en, pin_fall_en;
	logic [7:0] main_irq_control_reg;
	logic pin_change_summary_flag, irq_request, enter_irq;
	logic ext_meta, ext_sync, ext_prev, ext_edge;
	logic [PIN_COUNT-1:0] pin_meta, pin_sync, pin_prev, pin_event;
	logic aw_held, w_held, do_write, wr_byte, w_strobe;
	logic [11:0] aw_addr;
	logic [7:0] w_byte;
	logic [31:0] next_rdata;
	logic next_rerr;

	// Two-stage synchronisers; edge detection looks only at the second stage onward.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
			pin_meta <= RST_PINS;
			pin_sync <= RST_PINS;
			pin_prev <= RST_PINS;
		end else begin
			ext_meta <= ext_irq_pin;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
			pin_meta <= pin_change_pins;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	assign ext_edge = ext_pin_edge_select ? (ext_sync & ~ext_prev)
		: (~ext_sync & ext_prev);
	assign pin_event = (pin_sync & ~pin_prev & pin_rise_en) | (~pin_sync & pin_prev & pin_fall_en);

	// Instruction cycle phases Q1..Q4.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q_phase <= PH_Q1;
		end else begin
			q_phase <= q_phase + 2'h1;
		end
	end

	assign pin_change_summary_flag = |pin_flags;
	assign main_irq_control_reg = {global_irq_enable, peripheral_group_enable, tmr_en, ext_en,
		pinchg_en, tmr_flag, ext_pin_irq_flag, pin_change_summary_flag};

	// Global gating of the OR of core terms and group-gated peripheral terms.
	assign irq_request = global_irq_enable & ((tmr_en & tmr_flag) | (ext_en & ext_pin_irq_flag)
		| (pinchg_en & pin_change_summary_flag)
		| (peripheral_group_enable & (|(periph_flag_reg_one & periph_enable_reg_one)
		| |(periph_flag_reg_two & periph_enable_reg_two)
		| |(periph_flag_reg_three & periph_enable_reg_three))));
	// Decision is taken only at the Q1 edge, whatever instruction is in flight.
	assign enter_irq = (state == MIC_IDLE) && (q_phase == PH_Q1) && irq_request;

	// Entry sequence: flush for the Q2 to Q4 phases, then one instruction cycle each for save and vector load.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= MIC_IDLE;
		end else begin
			unique case (state)
				MIC_IDLE: begin
					if (enter_irq) begin
						state <= MIC_FLUSH;
					end
				end
				MIC_FLUSH: begin
					if (q_phase == PH_Q4) begin
						state <= MIC_SAVE;
					end
				end
				MIC_SAVE: begin
					if (q_phase == PH_Q4) begin
						state <= MIC_VECTOR;
					end
				end
				MIC_VECTOR: begin
					if (q_phase == PH_Q4) begin
						state <= MIC_IDLE;
					end
				end
			endcase
		end
	end

	assign irq_flush = (state == MIC_FLUSH);
	assign pc_load_addr = IRQ_VECTOR;

	// Push and vector load pulses, one clock at the start of their cycle; restore pulse one clock after the return.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stack_push <= 1'b0;
			pc_load <= 1'b0;
			ctx_restore <= 1'b0;
			push_addr <= 15'h0000;
		end else begin
			stack_push <= (state == MIC_FLUSH) && (q_phase == PH_Q4);
			pc_load <= (state == MIC_SAVE) && (q_phase == PH_Q4);
			ctx_restore <= return_from_irq_instr;
			if ((state == MIC_FLUSH) && (q_phase == PH_Q4)) begin
				push_addr <= core_pc;
			end
		end
	end

	// Shadow set; time-out and power-down bits are deliberately not captured.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			shadow_w <= 8'h00;
			shadow_status <= 3'h0;
			shadow_bsr <= 5'h00;
			shadow_fsr0 <= 16'h0000;
			shadow_fsr1 <= 16'h0000;
			shadow_pclath <= 7'h00;
		end else if ((state == MIC_FLUSH) && (q_phase == PH_Q4)) begin
			shadow_w <= core_w;
			shadow_status <= core_status;
			shadow_bsr <= core_bsr;
			shadow_fsr0 <= core_fsr0;
			shadow_fsr1 <= core_fsr1;
			shadow_pclath <= core_pclath;
		end
	end

	// Write channel: address and data taken in either order.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_byte = do_write && w_strobe;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_byte <= RST_BYTE;
			w_strobe <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_strobe <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[11:2] > OFS_SEQ_STATUS[11:2]) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control bits; hardware clear on entry and set on return beat software writes.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			global_irq_enable <= 1'b0;
			peripheral_group_enable <= 1'b0;
			tmr_en <= 1'b0;
			ext_en <= 1'b0;
			pinchg_en <= 1'b0;
			ext_pin_edge_select <= 1'b0;
			periph_enable_reg_one <= RST_BYTE;
			periph_enable_reg_two <= RST_BYTE;
			periph_enable_reg_three <= RST_BYTE;
			pin_rise_en <= RST_PINS;
			pin_fall_en <= RST_PINS;
		end else begin
			if (wr_byte) begin
				unique case ({aw_addr[11:2], 2'b00})
					OFS_MAIN_CTRL: begin
						global_irq_enable <= w_byte[BIT_GLOBAL_EN];
						peripheral_group_enable <= w_byte[BIT_PERIPH_EN];
						tmr_en <= w_byte[BIT_TMR_EN];
						ext_en <= w_byte[BIT_EXT_EN];
						pinchg_en <= w_byte[BIT_PINCHG_EN];
					end
					OFS_EN_ONE: periph_enable_reg_one <= w_byte;
					OFS_EN_TWO: periph_enable_reg_two <= w_byte;
					OFS_EN_THREE: periph_enable_reg_three <= w_byte;
					OFS_OPTION: ext_pin_edge_select <= w_byte[BIT_EDGE_SEL];
					OFS_PIN_RISE_EN: pin_rise_en <= w_byte[PIN_COUNT-1:0];
					OFS_PIN_FALL_EN: pin_fall_en <= w_byte[PIN_COUNT-1:0];
					default: begin
					end
				endcase
			end
			if (enter_irq) begin
				global_irq_enable <= 1'b0;
			end else if (return_from_irq_instr) begin
				global_irq_enable <= 1'b1;
			end
		end
	end

	// Flags: an event in the same clock as a software write still sets the flag.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tmr_flag <= 1'b0;
			ext_pin_irq_flag <= 1'b0;
			pin_flags <= RST_PINS;
			periph_flag_reg_one <= RST_BYTE;
			periph_flag_reg_two <= RST_BYTE;
			periph_flag_reg_three <= RST_BYTE;
		end else begin
			tmr_flag <= ((wr_byte && aw_addr[11:2] == OFS_MAIN_CTRL[11:2]) ? w_byte[BIT_TMR_FLAG]
				: tmr_flag) | timer_ovf_event;
			// The pin edge may land in any phase, so the flag may set between Q4 and Q1.
			ext_pin_irq_flag <= ((wr_byte && aw_addr[11:2] == OFS_MAIN_CTRL[11:2])
				? w_byte[BIT_EXT_FLAG] : ext_pin_irq_flag) | ext_edge;
			pin_flags <= ((wr_byte && aw_addr[11:2] == OFS_PIN_FLAGS[11:2])
				? w_byte[PIN_COUNT-1:0] : pin_flags) | pin_event;
			periph_flag_reg_one <= ((wr_byte && aw_addr[11:2] == OFS_FLAG_ONE[11:2])
				? w_byte : periph_flag_reg_one) | periph_event_one;
			periph_flag_reg_two <= ((wr_byte && aw_addr[11:2] == OFS_FLAG_TWO[11:2])
				? w_byte : periph_flag_reg_two) | periph_event_two;
			periph_flag_reg_three <= ((wr_byte && aw_addr[11:2] == OFS_FLAG_THREE[11:2])
				? w_byte : periph_flag_reg_three) | periph_event_three;
		end
	end

	// Read decode.
	always_comb begin
		next_rdata = 32'h00000000;
		next_rerr = 1'b0;
		unique case ({s_axi_araddr[11:2], 2'b00})
			OFS_MAIN_CTRL: next_rdata[7:0] = main_irq_control_reg;
			OFS_FLAG_ONE: next_rdata[7:0] = periph_flag_reg_one;
			OFS_FLAG_TWO: next_rdata[7:0] = periph_flag_reg_two;
			OFS_FLAG_THREE: next_rdata[7:0] = periph_flag_reg_three;
			OFS_EN_ONE: next_rdata[7:0] = periph_enable_reg_one;
			OFS_EN_TWO: next_rdata[7:0] = periph_enable_reg_two;
			OFS_EN_THREE: next_rdata[7:0] = periph_enable_reg_three;
			OFS_OPTION: next_rdata[BIT_EDGE_SEL] = ext_pin_edge_select;
			OFS_PIN_FLAGS: next_rdata[PIN_COUNT-1:0] = pin_flags;
			OFS_PIN_RISE_EN: next_rdata[PIN_COUNT-1:0] = pin_rise_en;
			OFS_PIN_FALL_EN: next_rdata[PIN_COUNT-1:0] = pin_fall_en;
			OFS_SEQ_STATUS: next_rdata[1:0] = state;
			default: next_rerr = 1'b1;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // mic_irq_ctrl
`default_nettype wire

// >>> test/mic_core_model.sv
// Behavioural core that follows the entry strobes of the interrupt controller.
// Assumes the bench pulses ret_req for one clock to execute a return.
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Controller side.
	input wire logic pc_load,
	input wire logic [14:0] pc_load_addr,
	input wire logic ret_req,
	// Core state.
	output logic [14:0] core_pc,
	output logic [7:0] core_w,
	output logic [2:0] core_status,
	output logic [4:0] core_bsr,
	output logic [15:0] core_fsr0,
	output logic [15:0] core_fsr1,
	output logic [6:0] core_pclath,
	output logic return_from_irq_instr
);
	// State moves every clock, so a shadow capture one clock early or late shows up.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			core_pc <= 15'h0000;
		else if (pc_load)
			core_pc <= pc_load_addr;
		else
			core_pc <= core_pc + 15'h0001;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			return_from_irq_instr <= 1'b0;
		else
			return_from_irq_instr <= ret_req;
	end
	assign core_w = core_pc[7:0] ^ 8'h5a;
	assign core_status = core_pc[2:0];
	assign core_bsr = core_pc[4:0];
	assign core_fsr0 = {1'b0, core_pc};
	assign core_fsr1 = ~{1'b0, core_pc};
	assign core_pclath = core_pc[6:0];
endmodule // mic_core_model
`default_nettype wire

// >>> test/mic_irq_ctrl_checker.sv
// Assertions on the interrupt entry and return sequence.
// Assumes it is bound to mic_irq_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_checker
	import mic_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Core side.
	input wire logic [1:0] q_phase,
	input wire logic [14:0] core_pc,
	input wire logic [7:0] core_w,
	input wire logic return_from_irq_instr,
	input wire logic irq_flush,
	input wire logic stack_push,
	input wire logic [14:0] push_addr,
	input wire logic pc_load,
	input wire logic [14:0] pc_load_addr,
	input wire logic ctx_restore,
	input wire logic [7:0] shadow_w,
	// Rest of the context that the shadow set must follow.
	input wire logic [2:0] core_status,
	input wire logic [4:0] core_bsr,
	input wire logic [15:0] core_fsr0,
	input wire logic [15:0] core_fsr1,
	input wire logic [6:0] core_pclath,
	input wire logic [2:0] shadow_status,
	input wire logic [4:0] shadow_bsr,
	input wire logic [15:0] shadow_fsr0,
	input wire logic [15:0] shadow_fsr1,
	input wire logic [6:0] shadow_pclath
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_flush;
		$rose(irq_flush) ##0 q_phase == 2'h1;
	endsequence
	sequence s_save_vector;
		##[1:4] $rose(stack_push) ##[3:5] pc_load;
	endsequence
	property p_entry_q1;
		$rose(irq_flush) |-> q_phase == 2'h1;
	endproperty
	a_entry_q1: assert property (p_entry_q1) else $error("entry off phase");
	property p_entry_steps;
		s_flush |-> s_save_vector;
	endproperty
	a_entry_steps: assert property (p_entry_steps) else $error("entry steps");
	property p_push_flush;
		$rose(stack_push) |-> $past(irq_flush);
	endproperty
	a_push_flush: assert property (p_push_flush) else $error("push no flush");
	property p_vector;
		pc_load |-> pc_load_addr == IRQ_VECTOR && q_phase == PH_Q1;
	endproperty
	a_vector: assert property (p_vector) else $error("bad vector");
	property p_shadow;
		$rose(stack_push) |-> shadow_w == $past(core_w) && push_addr == $past(core_pc);
	endproperty
	a_shadow: assert property (p_shadow) else $error("bad shadow");
	property p_shadow_rest;
		$rose(stack_push) |-> shadow_status == $past(core_status)
			&& shadow_bsr == $past(core_bsr) && shadow_fsr0 == $past(core_fsr0)
			&& shadow_fsr1 == $past(core_fsr1) && shadow_pclath == $past(core_pclath);
	endproperty
	a_shadow_rest: assert property (p_shadow_rest) else $error("bad shadow context");
	property p_hold;
		!stack_push ##1 !stack_push |-> $stable(shadow_w);
	endproperty
	a_hold: assert property (p_hold) else $error("shadow moved");
	property p_restore;
		return_from_irq_instr |=> ctx_restore;
	endproperty
	a_restore: assert property (p_restore) else $error("no restore");
	property p_phase;
		!$past(rst) |-> q_phase == $past(q_phase) + 2'h1;
	endproperty
	a_phase: assert property (p_phase) else $error("phase skip");
	property p_quiet;
		$fell(rst) |-> !irq_flush [*4];
	endproperty
	a_quiet: assert property (p_quiet) else $error("entry after reset");
endmodule // mic_irq_ctrl_checker
`default_nettype wire

// >>> test/mic_irq_ctrl_tb.sv
// Self-checking bench for the interrupt controller.
// Assumes the core model and the checker from the test folder.
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_tb;
	import mic_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, ret_req = 1'b0, ext_irq_pin = 1'b1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timer_ovf_event = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, seed = 32'h25, v;
	logic [7:0] periph_event_one = 8'h0, periph_event_two = 8'h0, periph_event_three = 8'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [5:0] pin_change_pins = 6'h00;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic irq_flush, stack_push, pc_load, ctx_restore, return_from_irq_instr;
	wire logic [1:0] s_axi_bresp, s_axi_rresp, q_phase;
	wire logic [31:0] s_axi_rdata;
	wire logic [14:0] core_pc, push_addr, pc_load_addr;
	wire logic [7:0] core_w, shadow_w;
	wire logic [2:0] core_status;
	wire logic [4:0] core_bsr;
	wire logic [15:0] core_fsr0, core_fsr1;
	wire logic [6:0] core_pclath;
	int bad_count = 0, samples_checked = 0, cyc = 0;
	logic [33:0] exp_rd[$];
	logic [1:0] exp_wr[$];
	mic_irq_ctrl u_mic_irq_ctrl (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.timer_ovf_event, .periph_event_one, .periph_event_two, .periph_event_three,
		.ext_irq_pin, .pin_change_pins, .q_phase, .core_pc, .core_w, .core_status,
		.core_bsr, .core_fsr0, .core_fsr1, .core_pclath, .return_from_irq_instr,
		.irq_flush, .stack_push, .push_addr, .pc_load, .pc_load_addr, .ctx_restore,
		.shadow_w, .shadow_status(), .shadow_bsr(), .shadow_fsr0(), .shadow_fsr1(),
		.shadow_pclath());
	mic_core_model u_mic_core_model (.sys_clk, .rst, .pc_load, .pc_load_addr, .ret_req,
		.core_pc, .core_w, .core_status, .core_bsr, .core_fsr0, .core_fsr1, .core_pclath,
		.return_from_irq_instr);
	initial forever #2 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic give_verdict();
		if (bad_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input logic [33:0] got, input logic [33:0] want);
		samples_checked++;
		if (got !== want) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
		end
	endtask
	// Responses are compared here, in the order their requests were issued.
	always @(posedge sys_clk) begin
		if (s_axi_rvalid && s_axi_rready)
			cmp({s_axi_rresp, s_axi_rdata}, exp_rd.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			cmp({32'h0, s_axi_bresp}, {32'h0, exp_wr.pop_front()});
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	// Ready is combinational, so it is sampled at the falling edge before the taking edge.
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
		logic ah, wh, bh;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		exp_wr.push_back(r);
		bh = 1'b0;
		while (!bh) begin
			@(negedge sys_clk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			@(posedge sys_clk);
			if (ah)
				s_axi_awvalid <= 1'b0;
			if (wh)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [7:0] d);
		logic hit, got;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		exp_rd.push_back({r, 24'h0, d});
		got = 1'b0;
		while (!got) begin
			@(negedge sys_clk);
			hit = s_axi_arvalid && s_axi_arready;
			got = s_axi_rvalid;
			@(posedge sys_clk);
			if (hit)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	// Counts clocks to the vector load; a window of 40 to 40 means no entry at all.
	task automatic entry(input int lo, input int hi);
		int n;
		n = 0;
		while (pc_load !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		cmp(n >= lo && n <= hi, 34'h1);
	endtask
	task automatic ret();
		@(posedge sys_clk);
		ret_req <= 1'b1;
		@(posedge sys_clk);
		ret_req <= 1'b0;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(OFS_MAIN_CTRL, RESP_OKAY, RST_BYTE);
		rd(OFS_EN_ONE, RESP_OKAY, RST_BYTE);
		rd(12'h040, RESP_SLVERR, 8'h00);
		wr(12'h040, 8'hff, RESP_SLVERR);
		v = rnd() | 32'h1;
		@(posedge sys_clk);
		{periph_event_three, periph_event_two, periph_event_one} <= v[23:0];
		timer_ovf_event <= 1'b1;
		@(posedge sys_clk);
		{periph_event_three, periph_event_two, periph_event_one} <= 24'h0;
		timer_ovf_event <= 1'b0;
		rd(OFS_FLAG_ONE, RESP_OKAY, v[7:0]);
		rd(OFS_FLAG_TWO, RESP_OKAY, v[15:8]);
		rd(OFS_FLAG_THREE, RESP_OKAY, v[23:16]);
		rd(OFS_MAIN_CTRL, RESP_OKAY, 8'h04);
		wr(OFS_PIN_RISE_EN, 8'h01, RESP_OKAY);
		pin_change_pins <= 6'h01;
		repeat (6) @(posedge sys_clk);
		rd(OFS_PIN_FLAGS, RESP_OKAY, 8'h01);
		wr(OFS_MAIN_CTRL, 8'h04, RESP_OKAY);
		rd(OFS_MAIN_CTRL, RESP_OKAY, 8'h05);
		wr(OFS_PIN_FLAGS, 8'h00, RESP_OKAY);
		rd(OFS_MAIN_CTRL, RESP_OKAY, 8'h04);
		// A write whose low byte strobe is off must leave the register alone.
		s_axi_wstrb <= 4'h0;
		wr(OFS_EN_TWO, 8'hff, RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(OFS_EN_TWO, RESP_OKAY, RST_BYTE);
		wr(OFS_MAIN_CTRL, 8'h24, RESP_OKAY);
		entry(40, 40);
		wr(OFS_MAIN_CTRL, 8'ha4, RESP_OKAY);
		entry(1, 12);
		rd(OFS_MAIN_CTRL, RESP_OKAY, 8'h24);
		ret();
		entry(1, 12);
		wr(OFS_MAIN_CTRL, 8'h20, RESP_OKAY);
		ret();
		entry(40, 40);
		rd(OFS_MAIN_CTRL, RESP_OKAY, 8'ha0);
		wr(OFS_EN_ONE, 8'h01, RESP_OKAY);
		entry(40, 40);
		wr(OFS_MAIN_CTRL, 8'he0, RESP_OKAY);
		entry(1, 12);
		wr(OFS_FLAG_ONE, 8'h00, RESP_OKAY);
		ret();
		repeat (rnd() & 32'h3) @(posedge sys_clk);
		timer_ovf_event <= 1'b1;
		@(posedge sys_clk);
		timer_ovf_event <= 1'b0;
		entry(8, 12);
		wr(OFS_OPTION, 8'h40, RESP_OKAY);
		wr(OFS_MAIN_CTRL, 8'h10, RESP_OKAY);
		ext_irq_pin <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rd(OFS_MAIN_CTRL, RESP_OKAY, 8'h10);
		ext_irq_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd(OFS_MAIN_CTRL, RESP_OKAY, 8'h12);
		wr(OFS_MAIN_CTRL, 8'h92, RESP_OKAY);
		entry(1, 12);
		wr(OFS_OPTION, 8'h00, RESP_OKAY);
		wr(OFS_MAIN_CTRL, 8'h10, RESP_OKAY);
		ret();
		repeat (rnd() & 32'h3) @(posedge sys_clk);
		ext_irq_pin <= 1'b0;
		entry(8, 16);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(OFS_MAIN_CTRL, RESP_OKAY, RST_BYTE);
		rd(OFS_OPTION, RESP_OKAY, RST_BYTE);
		give_verdict();
	end
endmodule // mic_irq_ctrl_tb
bind mic_irq_ctrl mic_irq_ctrl_checker u_mic_irq_ctrl_checker (.sys_clk, .rst, .q_phase,
	.core_pc, .core_w, .return_from_irq_instr, .irq_flush, .stack_push, .push_addr,
	.pc_load, .pc_load_addr, .ctx_restore, .shadow_w, .core_status, .core_bsr, .core_fsr0,
	.core_fsr1, .core_pclath, .shadow_status, .shadow_bsr, .shadow_fsr0, .shadow_fsr1,
	.shadow_pclath);
`default_nettype wire
